// >>> swc_defs.svh
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH
// Overview of operation
// - Low byte carries sample bits seven to zero.
// - High byte low nibble holds top bits; rest zero.
// - Microprocessor memory use locks out host access.
// - Samples fill segment circularly until trigger.
// - Next segment starts after previous completely filled.
// - First segment fills as soon as armed.
// - Trigger stops segment after post-trigger count.
// - Segment count and size selectable; pre and post.
// - Hysteresis needs second level crossed before re-arm.
// - Internal trigger from channel one or two level.
// - Service request raised on backplane LAM line.
// - Dual clock uses fast rate only in chosen intervals.
// - Near interval starts at trigger, capped by post count.
// - Each setting write leaves others untouched.
// - Eight range settings, four input modes.
// - Four dual timebase modes, rate two placement.
// - Triggers ignored when disabled, holdoff, post, dead time.
// - Pre-trigger share selectable in eighths.
// - 32-bit elapsed time per trigger when more than one segment is set, 1024 stored.

// Setting selectors for the config write port
`define SWC_CFG_RANGE 4'h0
`define SWC_CFG_INMODE 4'h1
`define SWC_CFG_PRE 4'h2
`define SWC_CFG_TMODE 4'h3
`define SWC_CFG_TSRC 4'h4
`define SWC_CFG_LVLA 4'h5
`define SWC_CFG_LVLB 4'h6
`define SWC_CFG_RATE1 4'h7
`define SWC_CFG_RATE2 4'h8
`define SWC_CFG_DUAL 4'h9
`define SWC_CFG_NEAR 4'hA
`define SWC_CFG_SEGLOG 4'hB
`define SWC_CFG_NSEGLOG 4'hC
`define SWC_CFG_TCTRL 4'hD
`define SWC_CFG_TSRES 4'hE

// Field limits and reset values
`define SWC_EIGHTHS 4'h8
`define SWC_SEG_LOG_MIN 4'hA
`define SWC_NSEG_LOG_MAX 4'hA
`define SWC_NIB_PAD 4'h0
`define SWC_RATE_RST 16'h0007
`define SWC_LVL_A_RST 8'h80
`define SWC_LVL_B_RST 8'h70
`define SWC_TSRES_MAX 3'h4

// Timing
`define SWC_CLK_NS 25
`define SWC_DEAD_NS 160000
`define SWC_TS_BASE_NS 1000
`endif

// >>> swc_pkg.sv
package swc_pkg;
	typedef enum logic [2:0] {SWC_IDLE, SWC_PRE, SWC_WAIT, SWC_POST, SWC_DEAD, SWC_DONE} swc_state_t;
	typedef enum logic [1:0] {SWC_IN_INV, SWC_IN_NONINV, SWC_IN_DIFF, SWC_IN_GND} swc_in_mode_t;
	typedef enum logic [2:0] {SWC_TM_POS, SWC_TM_NEG, SWC_TM_WIN, SWC_TM_HYSP, SWC_TM_HYSN}
		swc_trig_mode_t;
	typedef enum logic [1:0] {SWC_TS_EXT, SWC_TS_INT, SWC_TS_MAN} swc_trig_src_t;
endpackage : swc_pkg

// >>> swc_stream_if.sv
`timescale 1ns/10ps
// Valid/ready word stream between readout engine and FIFO
interface swc_stream_if #(parameter int W = 12);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : swc_stream_if

// >>> swc_fifo.sv
`timescale 1ns/10ps
module swc_fifo #(
	parameter int W = 12,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rstn,
	swc_stream_if.snk wr,
	swc_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("swc_fifo depth must be a power of two");
	end
	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;
	logic full;
	logic empty;
	// Extra pointer bit tells full from empty
	assign empty = (wp_q == rp_q);
	assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = mem_q[rp_q[AW-1:0]];
	// Write side
	always_ff @(posedge clk)
	begin
		if (!rstn)
			wp_q <= '0;
		else if (wr.valid && !full)
		begin
			mem_q[wp_q[AW-1:0]] <= wr.data;
			wp_q <= wp_q + 1'b1;
		end
	end
	// Read side
	always_ff @(posedge clk)
	begin
		if (!rstn)
			rp_q <= '0;
		else if (rd.ready && !empty)
			rp_q <= rp_q + 1'b1;
	end
endmodule : swc_fifo

// >>> swc_tstamp.sv
`timescale 1ns/10ps
`include "swc_defs.svh"
module swc_tstamp #(
	parameter int DEPTH = 1024,
	parameter int TICK_CYC = (`SWC_TS_BASE_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic arm,
	input wire logic trig,
	input wire logic [2:0] res,
	input wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic [31:0] rd_data_q,
	output logic [$clog2(DEPTH):0] count_q
);
	localparam int PW = $clog2(TICK_CYC + 1);
	if (TICK_CYC < 1 || DEPTH < 1)
	begin : g_bad_par
		$error("swc_tstamp parameters out of range");
	end
	logic [31:0] buf_q [DEPTH];
	logic [PW-1:0] pre_q;
	logic [13:0] dec_q;
	logic [31:0] elapsed_q;
	logic base_tick;
	logic unit_tick;
	// Ticks per stamp unit for each resolution step
	function automatic logic [13:0] decade(input logic [2:0] r);
		unique case (r)
			3'h0: decade = 14'h0001;
			3'h1: decade = 14'h000A;
			3'h2: decade = 14'h0064;
			3'h3: decade = 14'h03E8;
			default: decade = 14'h2710;
		endcase
	endfunction : decade
	assign base_tick = (pre_q == PW'(TICK_CYC - 1));
	assign unit_tick = base_tick && (dec_q == decade(res) - 14'h0001);
	// Microsecond prescaler
	always_ff @(posedge clk)
	begin
		if (!rstn || arm || base_tick)
			pre_q <= '0;
		else
			pre_q <= pre_q + 1'b1;
	end
	// Decade divider to the chosen sensitivity
	always_ff @(posedge clk)
	begin
		if (!rstn || arm || unit_tick)
			dec_q <= '0;
		else if (base_tick)
			dec_q <= dec_q + 14'h0001;
	end
	// Elapsed time restarts at arm and at each trigger; wraps at 32 bits
	always_ff @(posedge clk)
	begin
		if (!rstn || arm || trig)
			elapsed_q <= '0;
		else if (unit_tick)
			elapsed_q <= elapsed_q + 32'h00000001;
	end
	// Store one value per trigger until the buffer is full
	always_ff @(posedge clk)
	begin
		if (!rstn || arm)
			count_q <= '0;
		else if (trig && count_q < ($clog2(DEPTH) + 1)'(DEPTH))
		begin
			buf_q[count_q[$clog2(DEPTH)-1:0]] <= elapsed_q;
			count_q <= count_q + 1'b1;
		end
	end
	// Block readout port
	always_ff @(posedge clk)
	begin
		if (!rstn)
			rd_data_q <= '0;
		else
			rd_data_q <= buf_q[rd_idx];
	end
endmodule : swc_tstamp

// >>> swc_capture.sv
`timescale 1ns/10ps
`include "swc_defs.svh"
module swc_capture #(
	parameter int MEM_AW = 12,
	parameter int FIFO_DEPTH = 32,
	parameter int TS_DEPTH = 1024,
	parameter int DEAD_CYC = (`SWC_DEAD_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cfg_we,
	input wire logic [3:0] cfg_sel,
	input wire logic [15:0] cfg_data,
	input wire logic arm,
	input wire logic soft_trig,
	input wire logic ext_trig,
	input wire logic [11:0] adc_ch1,
	input wire logic [11:0] adc_ch2,
	input wire logic uproc_req,
	input wire logic lock_test,
	input wire logic rd_start,
	input wire logic [MEM_AW-1:0] rd_addr,
	input wire logic rd_abort,
	input wire logic host_rd,
	input wire logic lam_clr,
	input wire logic [$clog2(TS_DEPTH)-1:0] ts_rd_idx,
	output logic [7:0] rd_byte_q,
	output logic rd_ok_q,
	output logic lockout_q,
	output logic test_resp_q,
	output logic armed_q,
	output logic trigd_q,
	output logic lam_q,
	output logic clk_out_q,
	output logic [2:0] range_q,
	output swc_pkg::swc_in_mode_t in_mode_q,
	output logic [31:0] ts_data_q,
	output logic [$clog2(TS_DEPTH):0] ts_count_q
);
	localparam int DW = $clog2(DEAD_CYC + 1);
	if (MEM_AW < 10 || MEM_AW > 15 || DEAD_CYC < 1)
	begin : g_bad_par
		$error("swc_capture parameters out of range");
	end

	// Settings
	logic [3:0] pre_q;
	swc_pkg::swc_trig_mode_t tmode_q;
	swc_pkg::swc_trig_src_t tsrc_q;
	logic int_ch2_q;
	logic [7:0] lvl_a_q;
	logic [7:0] lvl_b_q;
	logic [15:0] rate1_q;
	logic [15:0] rate2_q;
	logic [1:0] dual_q;
	logic [MEM_AW:0] near_q;
	logic [3:0] seg_log_q;
	logic [3:0] nseg_log_q;
	logic trig_en_q;
	logic holdoff_q;
	logic [2:0] tsres_q;

	// Acquisition state
	swc_pkg::swc_state_t st_q;
	logic [15:0] div_q;
	logic tick_q;
	logic [MEM_AW-1:0] wr_off_q;
	logic [MEM_AW:0] fill_q;
	logic [MEM_AW:0] post_cnt_q;
	logic [10:0] seg_idx_q;
	logic [DW-1:0] dead_q;
	logic [11:0] mem_q [2**MEM_AW];

	// Trigger detection
	logic above_a_q;
	logic above_b_q;
	logic ext_q;
	logic hyst_ok_q;

	// Readout
	logic rd_active_q;
	logic [MEM_AW-1:0] rd_ptr_q;
	logic byte_hi_q;

	// Combinational helpers
	logic [MEM_AW:0] seg_len;
	logic [MEM_AW:0] post_total;
	logic [MEM_AW:0] pre_total;
	logic [MEM_AW:0] near_lim;
	logic use_rate2;
	logic writing;
	logic [11:0] trig_smp;
	logic above_a;
	logic above_b;
	logic int_evt;
	logic raw_trig;
	logic accept;
	logic seg_end;
	logic ts_trig;
	logic last_seg;

	swc_stream_if #(.W(12)) rd_in_if ();
	swc_stream_if #(.W(12)) rd_out_if ();

	// Segment length in samples, a power of two
	function automatic logic [MEM_AW:0] seg_size(input logic [3:0] lg);
		seg_size = (MEM_AW + 1)'(1) << lg;
	endfunction : seg_size

	// Samples kept after the trigger for a pre share in eighths
	function automatic logic [MEM_AW:0] post_count(input logic [3:0] lg, input logic [3:0] pre);
		logic [MEM_AW+4:0] prod;
		prod = {4'h0, seg_size(lg)} * {{(MEM_AW + 1){1'b0}}, `SWC_EIGHTHS - pre};
		post_count = prod[MEM_AW+3:3];
	endfunction : post_count

	// Absolute memory address of an offset within a segment
	function automatic logic [MEM_AW-1:0] mem_addr(input logic [10:0] seg,
		input logic [3:0] lg, input logic [MEM_AW-1:0] off);
		logic [MEM_AW+10:0] base;
		base = {{MEM_AW{1'b0}}, seg} << lg;
		mem_addr = base[MEM_AW-1:0] | off;
	endfunction : mem_addr

	assign seg_len = seg_size(seg_log_q);
	assign post_total = post_count(seg_log_q, pre_q);
	assign pre_total = seg_len - post_total;
	assign near_lim = (near_q < post_total) ? near_q : post_total;
	assign seg_end = tick_q && (st_q == swc_pkg::SWC_POST) && (post_cnt_q == post_total - 1'b1);
	assign last_seg = (seg_idx_q == (11'(1) << nseg_log_q) - 11'h001);
	assign writing = (st_q == swc_pkg::SWC_PRE) || (st_q == swc_pkg::SWC_WAIT)
		|| (st_q == swc_pkg::SWC_POST) || (st_q == swc_pkg::SWC_DEAD);

	// Rate two placement within post-trigger samples
	always_comb
	begin
		use_rate2 = 1'b0;
		if (st_q == swc_pkg::SWC_POST)
		begin
			unique case (dual_q)
				2'h0: use_rate2 = 1'b0;
				2'h1: use_rate2 = (post_cnt_q < near_lim);
				2'h2: use_rate2 = 1'b1;
				2'h3: use_rate2 = (post_cnt_q >= near_lim);
			endcase
		end
	end

	// Settings port: each selector touches only its own field
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			range_q <= '0;
			in_mode_q <= swc_pkg::SWC_IN_NONINV;
			pre_q <= '0;
			tmode_q <= swc_pkg::SWC_TM_POS;
			tsrc_q <= swc_pkg::SWC_TS_EXT;
			int_ch2_q <= 1'b0;
			lvl_a_q <= `SWC_LVL_A_RST;
			lvl_b_q <= `SWC_LVL_B_RST;
			rate1_q <= `SWC_RATE_RST;
			rate2_q <= `SWC_RATE_RST;
			dual_q <= '0;
			near_q <= '0;
			seg_log_q <= `SWC_SEG_LOG_MIN;
			nseg_log_q <= '0;
			trig_en_q <= 1'b1;
			holdoff_q <= 1'b0;
			tsres_q <= '0;
		end
		else if (cfg_we)
		begin
			unique case (cfg_sel)
				`SWC_CFG_RANGE: range_q <= cfg_data[2:0];
				`SWC_CFG_INMODE: in_mode_q <= swc_pkg::swc_in_mode_t'(cfg_data[1:0]);
				`SWC_CFG_PRE: pre_q <= (cfg_data[3:0] > `SWC_EIGHTHS) ? `SWC_EIGHTHS
					: cfg_data[3:0];
				`SWC_CFG_TMODE: tmode_q <= (cfg_data[2:0] > 3'h4) ? swc_pkg::SWC_TM_POS
					: swc_pkg::swc_trig_mode_t'(cfg_data[2:0]);
				`SWC_CFG_TSRC:
				begin
					tsrc_q <= (cfg_data[1:0] == 2'h3) ? swc_pkg::SWC_TS_EXT
						: swc_pkg::swc_trig_src_t'(cfg_data[1:0]);
					int_ch2_q <= cfg_data[4];
				end
				`SWC_CFG_LVLA: lvl_a_q <= cfg_data[7:0];
				`SWC_CFG_LVLB: lvl_b_q <= cfg_data[7:0];
				`SWC_CFG_RATE1: rate1_q <= cfg_data;
				`SWC_CFG_RATE2: rate2_q <= cfg_data;
				`SWC_CFG_DUAL: dual_q <= cfg_data[1:0];
				`SWC_CFG_NEAR: near_q <= cfg_data[MEM_AW:0];
				`SWC_CFG_SEGLOG:
					seg_log_q <= (cfg_data[3:0] < `SWC_SEG_LOG_MIN) ? `SWC_SEG_LOG_MIN
						: (cfg_data[3:0] > 4'(MEM_AW)) ? 4'(MEM_AW) : cfg_data[3:0];
				`SWC_CFG_NSEGLOG:
					nseg_log_q <= (cfg_data[3:0] > `SWC_NSEG_LOG_MAX) ? `SWC_NSEG_LOG_MAX
						: cfg_data[3:0];
				`SWC_CFG_TCTRL:
				begin
					trig_en_q <= cfg_data[0];
					holdoff_q <= cfg_data[1];
				end
				`SWC_CFG_TSRES: tsres_q <= (cfg_data[2:0] > `SWC_TSRES_MAX) ? `SWC_TSRES_MAX
					: cfg_data[2:0];
				default: ;
			endcase
		end
	end

	// Sample clock divider; the rate is chosen per sample
	always_ff @(posedge clk)
	begin
		if (!rstn || arm)
		begin
			div_q <= '0;
			tick_q <= 1'b0;
		end
		else if (div_q == 16'h0000)
		begin
			div_q <= use_rate2 ? rate2_q : rate1_q;
			tick_q <= writing;
		end
		else
		begin
			div_q <= div_q - 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// Buffered sample clock for chaining modules
	always_ff @(posedge clk)
	begin
		if (!rstn)
			clk_out_q <= 1'b0;
		else
			clk_out_q <= tick_q;
	end

	// Circular write; dead time already fills the next segment, never the finished one
	always_ff @(posedge clk)
	begin
		if (tick_q && writing && !((st_q == swc_pkg::SWC_DEAD) && last_seg))
			mem_q[mem_addr(seg_idx_q + 11'(st_q == swc_pkg::SWC_DEAD), seg_log_q,
				wr_off_q)] <= adc_ch1;
	end

	// Write offset wraps at the segment length; fill saturates at it
	always_ff @(posedge clk)
	begin
		if (!rstn || arm || seg_end)
		begin
			wr_off_q <= '0;
			fill_q <= '0;
		end
		else if (tick_q && writing)
		begin
			wr_off_q <= (wr_off_q + 1'b1) & MEM_AW'(seg_len - 1'b1);
			if (fill_q != seg_len)
				fill_q <= fill_q + 1'b1;
		end
	end

	// Level compare on the top eight bits of the chosen channel
	assign trig_smp = int_ch2_q ? adc_ch2 : adc_ch1;
	assign above_a = (trig_smp[11:4] >= lvl_a_q);
	assign above_b = (trig_smp[11:4] >= lvl_b_q);

	// Edge history follows the input while idle, so arming sees no false edge
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			above_a_q <= 1'b0;
			above_b_q <= 1'b0;
			ext_q <= 1'b0;
		end
		else
		begin
			ext_q <= ext_trig;
			if (tick_q || !writing)
			begin
				above_a_q <= above_a;
				above_b_q <= above_b;
			end
		end
	end

	// Internal trigger events per mode
	always_comb
	begin
		int_evt = 1'b0;
		if (tick_q)
		begin
			unique case (tmode_q)
				swc_pkg::SWC_TM_POS: int_evt = above_a && !above_a_q;
				swc_pkg::SWC_TM_NEG: int_evt = !above_a && above_a_q;
				swc_pkg::SWC_TM_WIN: int_evt = (above_a && !above_a_q) || (!above_b && above_b_q);
				swc_pkg::SWC_TM_HYSP: int_evt = above_a && !above_a_q && hyst_ok_q;
				swc_pkg::SWC_TM_HYSN: int_evt = !above_a && above_a_q && hyst_ok_q;
			endcase
		end
	end

	always_comb
	begin
		unique case (tsrc_q)
			swc_pkg::SWC_TS_INT: raw_trig = int_evt;
			swc_pkg::SWC_TS_MAN: raw_trig = soft_trig;
			default: raw_trig = ext_trig && !ext_q;
		endcase
	end

	// Disabled, holdoff, post and dead time all block acceptance
	assign accept = raw_trig && trig_en_q && ((st_q == swc_pkg::SWC_WAIT)
		|| ((st_q == swc_pkg::SWC_PRE) && !holdoff_q));
	assign ts_trig = accept && (nseg_log_q != 4'h0);

	// Hysteresis re-arm: second level crossing wins over a same-cycle clear
	always_ff @(posedge clk)
	begin
		if (!rstn || arm)
			hyst_ok_q <= 1'b1;
		else if (tick_q && (tmode_q == swc_pkg::SWC_TM_HYSP) && !above_b && above_b_q)
			hyst_ok_q <= 1'b1;
		else if (tick_q && (tmode_q == swc_pkg::SWC_TM_HYSN) && above_b && !above_b_q)
			hyst_ok_q <= 1'b1;
		else if (accept)
			hyst_ok_q <= 1'b0;
	end

	// Segment sequencer
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st_q <= swc_pkg::SWC_IDLE;
			seg_idx_q <= '0;
			post_cnt_q <= '0;
			dead_q <= '0;
		end
		else if (arm)
		begin
			st_q <= swc_pkg::SWC_PRE;
			seg_idx_q <= '0;
			post_cnt_q <= '0;
		end
		else
		begin
			unique case (st_q)
				swc_pkg::SWC_IDLE, swc_pkg::SWC_DONE: ;
				swc_pkg::SWC_PRE:
					if (accept)
					begin
						post_cnt_q <= '0;
						st_q <= (post_total == '0) ? swc_pkg::SWC_DEAD : swc_pkg::SWC_POST;
						dead_q <= '0;
					end
					else if (fill_q >= pre_total)
						st_q <= swc_pkg::SWC_WAIT;
				swc_pkg::SWC_WAIT:
					if (accept)
					begin
						post_cnt_q <= '0;
						st_q <= (post_total == '0) ? swc_pkg::SWC_DEAD : swc_pkg::SWC_POST;
						dead_q <= '0;
					end
				swc_pkg::SWC_POST:
					if (tick_q)
					begin
						post_cnt_q <= post_cnt_q + 1'b1;
						if (seg_end)
						begin
							st_q <= swc_pkg::SWC_DEAD;
							dead_q <= '0;
						end
					end
				swc_pkg::SWC_DEAD:
					if (dead_q == DW'(DEAD_CYC - 1))
					begin
						// Last segment ends the acquisition
						if (last_seg)
							st_q <= swc_pkg::SWC_DONE;
						else
						begin
							seg_idx_q <= seg_idx_q + 11'h001;
							st_q <= swc_pkg::SWC_PRE;
						end
					end
					else
						dead_q <= dead_q + 1'b1;
			endcase
		end
	end

	// Status lamps and service request; set wins over clear
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			armed_q <= 1'b0;
			trigd_q <= 1'b0;
			lam_q <= 1'b0;
		end
		else
		begin
			armed_q <= writing;
			trigd_q <= (st_q == swc_pkg::SWC_POST);
			if ((st_q == swc_pkg::SWC_DEAD) && (dead_q == DW'(DEAD_CYC - 1)) && last_seg)
				lam_q <= 1'b1;
			else if (lam_clr || arm)
				lam_q <= 1'b0;
		end
	end

	// Lockout follows the microprocessor's claim on the memory
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			lockout_q <= 1'b0;
			test_resp_q <= 1'b0;
		end
		else
		begin
			lockout_q <= uproc_req;
			test_resp_q <= lock_test && lockout_q;
		end
	end

	// Readout engine moves memory words into the FIFO; stalls under lockout
	assign rd_in_if.valid = rd_active_q && !lockout_q;
	assign rd_in_if.data = mem_q[rd_ptr_q];
	always_ff @(posedge clk)
	begin
		if (!rstn || rd_abort)
		begin
			rd_active_q <= 1'b0;
			rd_ptr_q <= '0;
		end
		else if (rd_start)
		begin
			rd_active_q <= 1'b1;
			rd_ptr_q <= rd_addr;
		end
		else if (rd_in_if.valid && rd_in_if.ready)
		begin
			rd_ptr_q <= rd_ptr_q + 1'b1;
			if (rd_ptr_q == '1)
				rd_active_q <= 1'b0;
		end
	end

	swc_fifo #(.W(12), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.wr(rd_in_if),
		.rd(rd_out_if)
	);

	// Host byte reads: low byte first, then padded high byte pops the word
	assign rd_out_if.ready = host_rd && byte_hi_q && !lockout_q;
	always_ff @(posedge clk)
	begin
		if (!rstn || rd_abort)
		begin
			byte_hi_q <= 1'b0;
			rd_byte_q <= '0;
			rd_ok_q <= 1'b0;
		end
		else if (host_rd)
		begin
			if (lockout_q || !rd_out_if.valid)
			begin
				rd_byte_q <= '0;
				rd_ok_q <= 1'b0;
			end
			else if (!byte_hi_q)
			begin
				rd_byte_q <= rd_out_if.data[7:0];
				rd_ok_q <= 1'b1;
				byte_hi_q <= 1'b1;
			end
			else
			begin
				rd_byte_q <= {`SWC_NIB_PAD, rd_out_if.data[11:8]};
				rd_ok_q <= 1'b1;
				byte_hi_q <= 1'b0;
			end
		end
		else
			rd_ok_q <= 1'b0;
	end

	swc_tstamp #(.DEPTH(TS_DEPTH)) u_tstamp (
		.clk(clk),
		.rstn(rstn),
		.arm(arm),
		.trig(ts_trig),
		.res(tsres_q),
		.rd_idx(ts_rd_idx),
		.rd_data_q(ts_data_q),
		.count_q(ts_count_q)
	);
endmodule : swc_capture

// >>> swc_capture_chk.sv
`timescale 1ns/10ps
module swc_capture_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cfg_we,
	input wire logic [3:0] cfg_sel,
	input wire logic [15:0] cfg_data,
	input wire logic arm,
	input wire logic uproc_req,
	input wire logic lock_test,
	input wire logic rd_abort,
	input wire logic host_rd,
	input wire logic [7:0] rd_byte_q,
	input wire logic rd_ok_q,
	input wire logic lockout_q,
	input wire logic test_resp_q,
	input wire logic armed_q,
	input wire logic trigd_q,
	input wire logic lam_q,
	input wire logic [2:0] range_q,
	input wire swc_pkg::swc_in_mode_t in_mode_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic phase_q;
	// Byte phase of the host stream; abort restarts pairing at the low byte
	always_ff @(posedge clk)
	begin
		if (!rstn || rd_abort)
			phase_q <= 1'b0;
		else if (rd_ok_q)
			phase_q <= ~phase_q;
	end
	// Named steps of the host and setting traffic
	sequence s_locked_rd;
		host_rd && lockout_q;
	endsequence
	sequence s_range_wr;
		cfg_we && cfg_sel == 4'h0;
	endsequence
	sequence s_mode_wr;
		cfg_we && cfg_sel == 4'h1;
	endsequence
	chk_lock_follow: assert property (1'b1 |=> lockout_q == $past(uproc_req))
		else $error("lockout does not follow processor request");
	chk_lock_query: assert property (1'b1 |=> test_resp_q == ($past(lock_test) && $past(lockout_q)))
		else $error("lock query answer wrong");
	chk_lock_refuse: assert property (s_locked_rd |=> !rd_ok_q && rd_byte_q == 8'h00)
		else $error("byte handed out during lockout");
	chk_ok_cause: assert property (rd_ok_q |-> $past(host_rd) && !$past(lockout_q))
		else $error("byte valid without a request");
	chk_high_pad: assert property (rd_ok_q && phase_q |-> rd_byte_q[7:4] == 4'h0)
		else $error("high byte upper nibble not zero");
	chk_arm_start: assert property (arm |-> ##2 armed_q)
		else $error("arm did not start digitizing");
	chk_post_armed: assert property (trigd_q |-> armed_q)
		else $error("post-trigger recording while not armed");
	chk_lam_end: assert property ($rose(lam_q) |=> !armed_q && !trigd_q)
		else $error("service request before acquisition end");
	chk_range_wr: assert property (s_range_wr |=> range_q == $past(cfg_data[2:0]))
		else $error("range setting not applied");
	chk_range_keep: assert property (!(cfg_we && cfg_sel == 4'h0) |=> $stable(range_q))
		else $error("range changed by another setting");
	chk_mode_wr: assert property (s_mode_wr |=> in_mode_q == $past(cfg_data[1:0]))
		else $error("input mode setting not applied");
endmodule : swc_capture_chk

// >>> swc_ctrl_model.sv
`timescale 1ns/10ps
// Crate controller side, taking sample bytes with a chosen pause between them
module swc_ctrl_model (
	input wire logic clk,
	input wire logic rd_ok_q,
	input wire logic [7:0] rd_byte_q,
	output logic host_rd
);
	initial host_rd = 1'b0;
	// One byte per request; the answer stands one cycle, so it is read then
	task automatic take(output logic [7:0] b, output logic ok);
		@(posedge clk);
		host_rd <= 1'b1;
		@(posedge clk);
		host_rd <= 1'b0;
		#1;
		ok = rd_ok_q;
		b = rd_byte_q;
	endtask : take
	// Low byte first; the upper nibble of the high byte is not trusted
	task automatic read_word(input int gap, output logic [11:0] smp, output logic [3:0] pad,
		output logic ok);
		logic [7:0] lo;
		logic [7:0] hi;
		logic ok_hi;
		take(lo, ok);
		repeat (gap) @(posedge clk);
		take(hi, ok_hi);
		smp = {hi[3:0], lo};
		pad = hi[7:4];
		ok = ok & ok_hi;
	endtask : read_word
endmodule : swc_ctrl_model

// >>> tb_segmented_waveform_capture.sv
`timescale 1ns/10ps
`include "swc_defs.svh"
module tb_segmented_waveform_capture;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cfg_we = 1'b0;
	logic [3:0] cfg_sel = 4'h0;
	logic [15:0] cfg_data = 16'h0000;
	logic [5:0] stb = 6'h00;
	logic [11:0] adc_ch2 = 12'h000;
	logic uproc_req = 1'b0;
	logic [9:0] ts_rd_idx = 10'h000;
	logic host_rd, rd_ok_q, lockout_q, test_resp_q, armed_q, trigd_q, lam_q, clk_out_q;
	logic [7:0] rd_byte_q;
	logic [2:0] range_q;
	swc_pkg::swc_in_mode_t in_mode_q;
	logic [31:0] ts_data_q;
	logic [10:0] ts_count_q;
	wire [2:0] mon = {lam_q, trigd_q, armed_q};
	int mismatches = 0;
	int total_checks = 0;
	// Short dead time keeps the run brief; strobes: arm, trig, query, start, clear, abort
	swc_capture #(.DEAD_CYC(20)) i_swc_capture (.clk, .rstn, .cfg_we, .cfg_sel, .cfg_data,
		.arm(stb[0]), .soft_trig(stb[1]), .ext_trig(1'b0), .adc_ch1(12'hA5C), .adc_ch2,
		.uproc_req, .lock_test(stb[2]), .rd_start(stb[3]), .rd_addr(12'hFD8), .rd_abort(stb[5]),
		.host_rd, .lam_clr(stb[4]), .ts_rd_idx, .rd_byte_q, .rd_ok_q, .lockout_q, .test_resp_q,
		.armed_q, .trigd_q, .lam_q, .clk_out_q, .range_q, .in_mode_q, .ts_data_q, .ts_count_q);
	swc_ctrl_model i_swc_ctrl_model (.clk, .rd_ok_q, .rd_byte_q, .host_rd);
	// Clock at 40 MHz
	always #12.5 clk = ~clk;
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask : check
	task automatic in_range(input string what, input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] got);
		total_checks++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			mismatches++;
			$display("wrong value %s: expected %0d to %0d, seen %0d", what, lo, hi, got);
		end
	endtask : in_range
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic cfg(input logic [3:0] sel, input logic [15:0] val);
		@(posedge clk);
		cfg_we <= 1'b1;
		cfg_sel <= sel;
		cfg_data <= val;
		@(posedge clk);
		cfg_we <= 1'b0;
	endtask : cfg
	task automatic pulse(input int b);
		@(posedge clk);
		stb[b] <= 1'b1;
		@(posedge clk);
		stb[b] <= 1'b0;
	endtask : pulse
	// Bounded wait on a status flag; running out ends the run
	task automatic wait_for(input int b, input logic v, input int lim);
		int n;
		n = 0;
		while (mon[b] !== v)
		begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim)
			begin
				mismatches++;
				$display("wrong value wait on flag %0d: expected %0b, seen %0b", b, v, mon[b]);
				end_of_test();
			end
		end
	endtask : wait_for
	// A manual trigger that must be ignored leaves the post flag low
	task automatic t_refused;
		logic [3:0] n;
		n = 4'h0;
		pulse(1);
		repeat (8)
		begin
			@(posedge clk);
			#1;
			n = n + {3'h0, trigd_q};
		end
		check("refused trigger", 32'h0, {28'h0, n});
	endtask : t_refused
	// One segment; post length shows where the slower rate two was used
	task automatic t_segment(input logic [15:0] mode, input int exp, input bit intl);
		int n;
		n = 0;
		cfg(`SWC_CFG_DUAL, mode);
		if (intl)
			adc_ch2 <= 12'hFFF;
		else
			pulse(1);
		wait_for(1, 1'b1, 6);
		while (trigd_q === 1'b1 && n < 3000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		adc_ch2 <= 12'h000;
		in_range("post length", exp - 2, exp + 2, n);
	endtask : t_segment
	// Stall until the buffer is full, test lockout, then drain until empty
	task automatic t_readout;
		logic [11:0] smp;
		logic [3:0] pad;
		logic ok;
		pulse(3);
		repeat (60) @(posedge clk);
		uproc_req <= 1'b1;
		repeat (2) @(posedge clk);
		pulse(2);
		#1;
		check("lock query", 32'h1, {31'h0, test_resp_q});
		i_swc_ctrl_model.read_word(0, smp, pad, ok);
		check("locked read", 32'h0, {31'h0, ok});
		@(posedge clk);
		uproc_req <= 1'b0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 40; i++)
		begin
			i_swc_ctrl_model.read_word(i % 2 * 3, smp, pad, ok);
			check("sample", 32'hA5C, {20'h0, smp});
			check("pad nibble", 32'h0, {28'h0, pad});
			check("read ok", 32'h1, {31'h0, ok});
		end
		i_swc_ctrl_model.read_word(0, smp, pad, ok);
		check("empty read", 32'h0, {31'h0, ok});
	endtask : t_readout
	// Main sequence: settings, four segments, service request, readout
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		check("idle flags", 32'h0, {28'h0, armed_q, trigd_q, lam_q, lockout_q});
		check("reset mode", 32'h1, {30'h0, in_mode_q});
		for (int i = 0; i < 8; i++)
		begin
			cfg(`SWC_CFG_RANGE, 16'(i));
			@(posedge clk);
			#1;
			check("range", i, {29'h0, range_q});
		end
		for (int i = 0; i < 4; i++)
		begin
			cfg(`SWC_CFG_INMODE, 16'(i));
			@(posedge clk);
			#1;
			check("input mode", i, {30'h0, in_mode_q});
			check("range kept", 32'h7, {29'h0, range_q});
		end
		cfg(`SWC_CFG_NSEGLOG, 16'h0002);
		cfg(`SWC_CFG_PRE, 16'h0004);
		cfg(`SWC_CFG_TSRC, 16'h0002);
		cfg(`SWC_CFG_RATE1, 16'h0000);
		cfg(`SWC_CFG_RATE2, 16'h0001);
		cfg(`SWC_CFG_NEAR, 16'h0040);
		cfg(`SWC_CFG_TCTRL, 16'h0003);
		pulse(0);
		@(posedge clk);
		#1;
		check("armed", 32'h1, {31'h0, armed_q});
		repeat (100) @(posedge clk);
		check("sample clock out", 32'h1, {31'h0, clk_out_q});
		t_refused();
		repeat (1100) @(posedge clk);
		cfg(`SWC_CFG_TCTRL, 16'h0000);
		t_refused();
		cfg(`SWC_CFG_TCTRL, 16'h0001);
		t_segment(16'h0000, 512, 1'b0);
		t_refused();
		repeat (1100) @(posedge clk);
		t_segment(16'h0001, 576, 1'b0);
		repeat (1100) @(posedge clk);
		t_segment(16'h0002, 1024, 1'b0);
		repeat (1100) @(posedge clk);
		cfg(`SWC_CFG_TSRC, 16'h0011);
		t_segment(16'h0003, 960, 1'b1);
		wait_for(2, 1'b1, 200);
		@(posedge clk);
		#1;
		check("armed at end", 32'h0, {31'h0, armed_q});
		check("stamp count", 32'h4, {21'h0, ts_count_q});
		@(posedge clk);
		ts_rd_idx <= 10'h001;
		repeat (2) @(posedge clk);
		#1;
		in_range("stamp", 1, 1000, ts_data_q);
		pulse(4);
		@(posedge clk);
		#1;
		check("lam cleared", 32'h0, {31'h0, lam_q});
		t_readout();
		end_of_test();
	end
endmodule : tb_segmented_waveform_capture
bind swc_capture swc_capture_chk i_swc_capture_chk (.clk, .rstn, .cfg_we, .cfg_sel, .cfg_data,
	.arm, .uproc_req, .lock_test, .rd_abort, .host_rd, .rd_byte_q, .rd_ok_q, .lockout_q,
	.test_resp_q, .armed_q, .trigd_q, .lam_q, .range_q, .in_mode_q);
